// ==== bench/sas_conv_model.sv ====
`timescale 1ns/1ns
module sas_conv_model (
  input wire sys_clk,
  input wire rst,
  input wire convStart_ff,
  input wire convClk_ff,
  input wire [3:0] chanSel_ff,
  output wire [11:0] convResultIn
);
  reg busy_ff;
  reg [3:0] tad_ff;
  reg [3:0] chan_ff;
  // Result names its input; outside a conversion the inverse shows
  assign convResultIn = busy_ff ? {chan_ff, 8'h5A} : ~{chan_ff, 8'h5A};
  always @(posedge sys_clk) begin
    if (rst) begin
      busy_ff <= 1'b0;
    end else if (convStart_ff) begin
      busy_ff <= 1'b1;
      tad_ff <= 4'h0;
      chan_ff <= chanSel_ff;
    end else if (convClk_ff && busy_ff) begin
      tad_ff <= tad_ff + 4'h1;
      if (tad_ff == 4'hD)
        busy_ff <= 1'b0;
    end
  end
endmodule // sas_conv_model

// ==== bench/sas_sar_adc_sequencer_asserts.sv ====
`timescale 1ns/1ns
module sas_sar_adc_sequencer_asserts (
  input wire sys_clk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire sampleOn_ff,
  input wire convStart_ff,
  input wire convClk_ff,
  input wire convIrqFlag_ff
);
  reg [4:0] tadSeen_ff;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  // Converter clocks seen since the last conversion start
  always @(posedge sys_clk) begin
    if (rst || convStart_ff)
      tadSeen_ff <= 5'h00;
    else if (convClk_ff)
      tadSeen_ff <= tadSeen_ff + 5'h01;
  end
  a_ack_one: assert property (s_req |=> s_pulse) else $error("ack not one pulse after request");
  a_ack_source: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000) else $error("read upper half not zero");
  a_start_pulse: assert property (convStart_ff |=> !convStart_ff) else $error("start pulse too long");
  a_start_acq: assert property (convStart_ff |-> $past(sampleOn_ff) && !sampleOn_ff) else $error("start not ending acq");
  a_tad_count: assert property (convClk_ff |-> tadSeen_ff < 5'h0E) else $error("more than 14 converter clocks");
  a_irq_after: assert property ($rose(convIrqFlag_ff) |-> tadSeen_ff == 5'h0D && convClk_ff)
    else $error("flag without full conversion");
  a_no_clk_acq: assert property (sampleOn_ff |-> !convClk_ff) else $error("converter clock during acquisition");
endmodule // sas_sar_adc_sequencer_asserts
bind sas_sar_adc_sequencer sas_sar_adc_sequencer_asserts u_chk (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sampleOn_ff(sampleOn_ff),
  .convStart_ff(convStart_ff), .convClk_ff(convClk_ff), .convIrqFlag_ff(convIrqFlag_ff));

// ==== bench/sas_sar_adc_sequencer_test.sv ====
`timescale 1ns/1ns
module sas_sar_adc_sequencer_test;
  reg sys_clk = 0, rst = 1, cyc = 0, stb = 0, wbWe = 0, rcClk = 0, tmrTrig = 0, extTrig = 0;
  reg [1:0] rcDiv = 2'h0;
  reg [7:0] adr = 8'h00;
  reg [31:0] wdat = 32'h0000_0000;
  reg [15:0] rd;
  int fails = 0, checksDone = 0;
  wire [31:0] rdat;
  wire ack, sOn, cStart, cClk, irq;
  wire [3:0] chan;
  wire [1:0] vref;
  wire [11:0] res;
  always #20 sys_clk = ~sys_clk;
  // Free-running internal oscillator, eight system clocks a period
  always @(posedge sys_clk) begin
    rcDiv <= rcDiv + 2'h1;
    if (rcDiv == 2'h3)
      rcClk <= ~rcClk;
  end
  sas_sar_adc_sequencer DUT (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wbWe),
    .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .rcClkIn(rcClk),
    .timerTrigIn(tmrTrig), .extTrigIn(extTrig), .convResultIn(res), .sampleOn_ff(sOn), .convStart_ff(cStart),
    .convClk_ff(cClk), .chanSel_ff(chan), .vrefSel_ff(vref), .convIrqFlag_ff(irq));
  sas_conv_model u_core (.sys_clk(sys_clk), .rst(rst), .convStart_ff(cStart), .convClk_ff(cClk),
    .chanSel_ff(chan), .convResultIn(res));
  task finish_test;
    $display("Checks %0d mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checksDone++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  task wb(input logic we, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    cyc <= 1;
    stb <= 1;
    wbWe <= we;
    adr <= a;
    wdat <= {16'h0000, d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = rdat[15:0];
    cyc <= 0;
    stb <= 0;
    if (n >= 50) begin
      chk("bus ack", 16'h0001, 16'h0000);
      finish_test;
    end
  endtask
  task rdc(input string nm, input logic [7:0] a, input logic [15:0] e);
    wb(0, a, 16'h0000);
    chk(nm, e, rd);
  endtask
  task wait_flag;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 20000) begin
      @(posedge sys_clk);
      n++;
    end
    chk("flag", 16'h0001, {15'h0000, irq});
    if (n >= 20000)
      finish_test;
    else
      wb(1, 8'h18, 16'h0001);
  endtask
  // Configuration only while the module is off
  task setup(input logic [15:0] c2, c3, insel, scan);
    wb(1, 8'h00, 16'h0000);
    wb(1, 8'h04, c2);
    wb(1, 8'h08, c3);
    wb(1, 8'h0C, insel);
    wb(1, 8'h14, scan);
  endtask
  task sc_split;
    setup(16'h0002, 16'h0180, 16'h0005, 16'h0000);
    wb(1, 8'h00, 16'h80E6);
    wait_flag;
    wait_flag;
    wb(1, 8'h00, 16'h0000);
    rdc("buf0", 8'h40, 16'h055A);
    rdc("buf8", 8'h60, 16'h055A);
    wb(1, 8'h40, 16'h0ABC);
    rdc("buf0 ro", 8'h40, 16'h055A);
  endtask
  task sc_alt;
    setup(16'h0005, 16'h0108, 16'h0D03, 16'h0000);
    wb(1, 8'h00, 16'h80E6);
    wait_flag;
    wb(1, 8'h00, 16'h0000);
    rdc("alt a", 8'h40, 16'h035A);
    rdc("alt b", 8'h44, 16'h0000);
  endtask
  task sc_scan;
    setup(16'h2404, 16'h0108, 16'h0000, 16'h0044);
    wb(1, 8'h00, 16'h80E6);
    wait_flag;
    chk("vref", 16'h0001, {14'h0000, vref});
    wb(1, 8'h00, 16'h0000);
    rdc("scan lo", 8'h40, 16'h025A);
    rdc("scan hi", 8'h44, 16'h065A);
  endtask
  task sc_trig(input logic [15:0] code);
    setup(16'h0000, 16'h0108, 16'h0009, 16'h0000);
    wb(1, 8'h00, 16'h8002 | (code << 5));
    repeat (8) @(posedge sys_clk);
    chk("no early flag", 16'h0000, {15'h0000, irq});
    if (code == 16'h0001)
      extTrig <= 1;
    else
      tmrTrig <= 1;
    repeat (8) @(posedge sys_clk);
    extTrig <= 0;
    tmrTrig <= 0;
    wait_flag;
    wb(1, 8'h00, 16'h0000);
    rdc("trig buf", 8'h40, 16'h095A);
  endtask
  task sc_sw;
    setup(16'h0000, 16'h0108, 16'h0007, 16'h0000);
    wb(1, 8'h00, 16'h8102);
    repeat (5) @(posedge sys_clk);
    wb(1, 8'h00, 16'h8100);
    wait_flag;
    rdc("done", 8'h00, 16'h8101);
    rdc("signed", 8'h40, 16'hFF5A);
    wb(1, 8'h00, 16'h8200);
    rdc("frac", 8'h40, 16'h75A0);
    wb(1, 8'h00, 16'h8300);
    rdc("signed frac", 8'h40, 16'hF5A0);
  endtask
  task sc_abort;
    int n;
    n = 0;
    setup(16'h0000, 16'h013F, 16'h000B, 16'h0000);
    wb(1, 8'h00, 16'h80E6);
    while (cStart !== 1'b1 && n < 500) begin
      @(posedge sys_clk);
      n++;
    end
    chk("start seen", 16'h0001, {15'h0000, cStart});
    if (n >= 500)
      finish_test;
    else begin
      n = 0;
      while (cClk !== 1'b1 && n < 200) begin
        @(posedge sys_clk);
        n++;
      end
      chk("tad period", 16'h0040, n[15:0]);
      repeat (100) @(posedge sys_clk);
      wb(1, 8'h00, 16'h0000);
      repeat (2000) @(posedge sys_clk);
      chk("abort flag", 16'h0000, {15'h0000, irq});
      rdc("abort buf", 8'h40, 16'h075A);
    end
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 0;
    rdc("ctrl2 rst", 8'h04, 16'h0000);
    rdc("unmapped", 8'h30, 16'h0000);
    sc_split;
    sc_alt;
    sc_scan;
    sc_trig(16'h0001);
    sc_trig(16'h0002);
    sc_sw;
    sc_abort;
    finish_test;
  end
endmodule // sas_sar_adc_sequencer_test

// ==== core/sas_regs.vh ====
`ifndef SAS_REGS_VH
`define SAS_REGS_VH

// Register byte offsets (32-bit words)
`define SAS_OFS_CTRL1 8'h00
`define SAS_OFS_CTRL2 8'h04
`define SAS_OFS_CTRL3 8'h08
`define SAS_OFS_INSEL 8'h0C
`define SAS_OFS_PCFG 8'h10
`define SAS_OFS_SCAN 8'h14
`define SAS_OFS_FLAG 8'h18
`define SAS_OFS_BUF 8'h40

// First control register fields
`define SAS_C1_ON 15
`define SAS_C1_FORMAT_FIELD_LO 8
`define SAS_C1_TRIG_LO 5
`define SAS_C1_AUTO_SAMPLE_BIT 2
`define SAS_C1_SAMPLE_BIT 1
`define SAS_C1_DONE 0

// Second control register fields
`define SAS_C2_VREF_LO 13
`define SAS_C2_SCAN 10
`define SAS_C2_HALF 7
`define SAS_C2_SAMPLES_PER_INTERRUPT_LO 2
`define SAS_C2_SPLIT 1
`define SAS_C2_ALT 0

// Third control register fields
`define SAS_C3_AUTO_SAMPLE_CLOCKS_LO 8
`define SAS_C3_RC 7
`define SAS_C3_DIV_LO 0

// Input select register fields
`define SAS_IS_MUXA_LO 0
`define SAS_IS_MUXB_LO 8

// Flag register fields
`define SAS_FL_IF 0

// Trigger source codes
`define SAS_TRIG_SW 3'h0
`define SAS_TRIG_EXT 3'h1
`define SAS_TRIG_TMR 3'h2
`define SAS_TRIG_AUTO 3'h7

// Reset values
`define SAS_RST_REG16 16'h0000

// Timing: converter clocks per conversion, first absent input
`define SAS_CONV_TADS 4'hE
`define SAS_FIRST_ABSENT 4'hD

`endif

// ==== core/sas_sar_adc_sequencer.v ====
`timescale 1ns/1ns
`include "sas_regs.vh"

// Contract
// R1 - Sixteen-word 12-bit result buffer, read-only
// R2 - Setting sample bit starts acquisition
// R3 - Store each result; flag after programmed count
// R4 - One to sixteen samples per interrupt
// R5 - Split buffer halves swap each interrupt
// R6 - Sample count field sits at bits 5:2
// R7 - Alternate off samples group A only
// R8 - Alternate on: A then B, alternating
// R9 - Scan enable bit 10 steps group A
// R10 - Scan low to high, restart each interrupt
// R11 - Inputs 13 to 15 convert to zero
// R12 - Code 000: clearing sample bit converts
// R13 - Code 111: convert after programmed clocks
// R14 - Other codes take timer or external triggers; codes 011 to 110 never trigger a conversion
// R15 - Module off aborts, buffer keeps last value
// R16 - Module off beats automatic start
// R17 - Conversion lasts fourteen converter clocks
// R18 - Converter clock is half-instruction times divider+1
// R19 - RC select uses internal RC clock
// R20 - Software leaves config alone while on
// R21 - Software keeps converter clock period long enough
// R22 - Software selects conversion reference source
// R23 - Auto-sample bit restarts sampling automatically
// R24 - Format field picks one of four
// R25 - Unsplit buffer restarts at word zero
// R26 - Module off stops clocking, ignores triggers
module sas_sar_adc_sequencer (
  input wire sys_clk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire rcClkIn,
  input wire timerTrigIn,
  input wire extTrigIn,
  input wire [11:0] convResultIn,
  output reg sampleOn_ff,
  output reg convStart_ff,
  output reg convClk_ff,
  output reg [3:0] chanSel_ff,
  output reg [1:0] vrefSel_ff,
  output reg convIrqFlag_ff
);

  localparam ST_IDLE = 3'b001;
  localparam ST_SAMPLE = 3'b010;
  localparam ST_CONVERT = 3'b100;

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [15:0] ctrl1_ff;
  reg [15:0] ctrl2_ff;
  reg [15:0] ctrl3_ff;
  reg [15:0] inSel_ff;
  reg [15:0] portCfg_ff;
  reg [15:0] scanSel_ff;
  reg sampleBit_ff;
  reg doneBit_ff;
  reg bufHalf_ff;
  reg altPhase_ff;
  reg [3:0] sampleCnt_ff;
  reg [5:0] divCnt_ff;
  reg [4:0] samcCnt_ff;
  reg [3:0] tadCnt_ff;
  reg [11:0] resultBuf [0:15];
  reg [2:0] rcSync_ff;
  reg [2:0] tmrSync_ff;
  reg [2:0] extSync_ff;
  reg rcStable_ff;
  reg tmrStable_ff;
  reg extStable_ff;

  wire moduleOn = ctrl1_ff[`SAS_C1_ON];
  wire [1:0] formatSel = ctrl1_ff[`SAS_C1_FORMAT_FIELD_LO +: 2];
  wire [2:0] trigSrc = ctrl1_ff[`SAS_C1_TRIG_LO +: 3];
  wire autoSample = ctrl1_ff[`SAS_C1_AUTO_SAMPLE_BIT];
  wire scanEn = ctrl2_ff[`SAS_C2_SCAN];
  wire [3:0] samplesPerIrq = ctrl2_ff[`SAS_C2_SAMPLES_PER_INTERRUPT_LO +: 4];
  wire bufSplit = ctrl2_ff[`SAS_C2_SPLIT];
  wire altEn = ctrl2_ff[`SAS_C2_ALT];
  wire [4:0] autoSampleClks = ctrl3_ff[`SAS_C3_AUTO_SAMPLE_CLOCKS_LO +: 5];
  wire rcSel = ctrl3_ff[`SAS_C3_RC];
  wire [5:0] clkDiv = ctrl3_ff[`SAS_C3_DIV_LO +: 6];

  wire busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire busWr = busReq & wb_we_i;

  // Position of the n-th set bit, scanning from bit 0 upward
  function [3:0] nth_selected;
    input [15:0] sel;
    input [3:0] n;
    integer i;
    reg [4:0] seen;
    reg found;
    begin
      nth_selected = 4'h0;
      seen = 5'h00;
      found = 1'b0;
      for (i = 0; i < 16; i = i + 1) begin
        if (sel[i] && !found) begin
          if (seen[3:0] == n) begin
            nth_selected = i[3:0];
            found = 1'b1;
          end
          seen = seen + 5'h01;
        end
      end
    end
  endfunction

  // Result word as presented on the bus
  function [15:0] format_word;
    input [11:0] d;
    input [1:0] fmt;
    begin
      case (fmt)
        2'h0: format_word = {4'h0, d};
        2'h1: format_word = {{5{~d[11]}}, d[10:0]};
        2'h2: format_word = {d, 4'h0};
        default: format_word = {~d[11], d[10:0], 4'h0};
      endcase
    end
  endfunction

  // Merge a write into a 16-bit register under byte lanes
  function [15:0] lane_merge;
    input [15:0] old;
    input [15:0] wr;
    input [1:0] sel;
    begin
      lane_merge = {sel[1] ? wr[15:8] : old[15:8], sel[0] ? wr[7:0] : old[7:0]};
    end
  endfunction

  // Outside inputs: three flops, a level change counts when stages two and three agree
  always @(posedge sys_clk) begin
    if (rst) begin
      rcSync_ff <= 3'h0;
      tmrSync_ff <= 3'h0;
      extSync_ff <= 3'h0;
      rcStable_ff <= 1'b0;
      tmrStable_ff <= 1'b0;
      extStable_ff <= 1'b0;
    end else begin
      rcSync_ff <= {rcSync_ff[1:0], rcClkIn};
      tmrSync_ff <= {tmrSync_ff[1:0], timerTrigIn};
      extSync_ff <= {extSync_ff[1:0], extTrigIn};
      if (rcSync_ff[1] == rcSync_ff[2]) begin
        rcStable_ff <= rcSync_ff[2];
      end
      if (tmrSync_ff[1] == tmrSync_ff[2]) begin
        tmrStable_ff <= tmrSync_ff[2];
      end
      if (extSync_ff[1] == extSync_ff[2]) begin
        extStable_ff <= extSync_ff[2];
      end
    end
  end

  wire rcRise = rcSync_ff[1] & rcSync_ff[2] & ~rcStable_ff;
  wire tmrRise = tmrSync_ff[1] & tmrSync_ff[2] & ~tmrStable_ff;
  wire extRise = extSync_ff[1] & extSync_ff[2] & ~extStable_ff;

  // Converter clock: half-instruction clock is one sys_clk, divided by divider+1
  wire divWrap = (divCnt_ff == clkDiv);
  wire tadTick = moduleOn & (rcSel ? rcRise : divWrap); // R18 R19 R26

  always @(posedge sys_clk) begin
    if (rst || !moduleOn || rcSel || divWrap) begin
      divCnt_ff <= 6'h00; // R18
    end else begin
      divCnt_ff <= divCnt_ff + 6'h01;
    end
  end

  // Channel for the current sequence
  wire [3:0] scanIdx = altEn ? {1'b0, sampleCnt_ff[3:1]} : sampleCnt_ff;
  wire [3:0] muxAChan = scanEn ? nth_selected(scanSel_ff, scanIdx) : inSel_ff[`SAS_IS_MUXA_LO +: 4]; // R9 R10
  wire [3:0] curChan = (altEn && altPhase_ff) ? inSel_ff[`SAS_IS_MUXB_LO +: 4] : muxAChan; // R7 R8

  // Conversion trigger selection
  wire samcReached = (samcCnt_ff + 5'h01 >= autoSampleClks) & tadTick; // R13
  reg convTrig;
  always @* begin
    case (trigSrc)
      `SAS_TRIG_SW: convTrig = ~sampleBit_ff; // R12
      `SAS_TRIG_EXT: convTrig = extRise; // R14
      `SAS_TRIG_TMR: convTrig = tmrRise; // R14
      `SAS_TRIG_AUTO: convTrig = samcReached; // R13
      default: convTrig = 1'b0;
    endcase
  end

  wire convDone = state_ff[2] & tadTick & (tadCnt_ff == `SAS_CONV_TADS - 4'h1); // R17
  wire lastOfGroup = convDone & moduleOn & (sampleCnt_ff == samplesPerIrq); // R4 R6
  wire [3:0] wrIdx = {bufSplit & bufHalf_ff, 3'h0} + sampleCnt_ff; // R5 R25

  // Sequencer
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (moduleOn && sampleBit_ff) begin
          nxt_state = ST_SAMPLE; // R2
        end
      end
      ST_SAMPLE: begin
        if (!moduleOn) begin
          nxt_state = ST_IDLE; // R16 R26
        end else if (convTrig) begin
          nxt_state = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (!moduleOn) begin
          nxt_state = ST_IDLE; // R15
        end else if (convDone) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      samcCnt_ff <= 5'h00;
      tadCnt_ff <= 4'h0;
      sampleCnt_ff <= 4'h0;
      bufHalf_ff <= 1'b0;
      altPhase_ff <= 1'b0;
      sampleOn_ff <= 1'b0;
      convStart_ff <= 1'b0;
      convClk_ff <= 1'b0;
      chanSel_ff <= 4'h0;
      vrefSel_ff <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      sampleOn_ff <= nxt_state[1];
      convStart_ff <= state_ff[1] & nxt_state[2];
      convClk_ff <= state_ff[2] & moduleOn & tadTick; // R26
      chanSel_ff <= curChan;
      vrefSel_ff <= ctrl2_ff[`SAS_C2_VREF_LO +: 2]; // R22
      if (!state_ff[1]) begin
        samcCnt_ff <= 5'h00;
      end else if (tadTick) begin
        samcCnt_ff <= samcCnt_ff + 5'h01;
      end
      if (!state_ff[2]) begin
        tadCnt_ff <= 4'h0;
      end else if (tadTick) begin
        tadCnt_ff <= tadCnt_ff + 4'h1; // R17
      end
      if (lastOfGroup) begin
        sampleCnt_ff <= 4'h0; // R10 R25
        altPhase_ff <= 1'b0;
        if (bufSplit) begin
          bufHalf_ff <= ~bufHalf_ff; // R5
        end
      end else if (convDone && moduleOn) begin
        sampleCnt_ff <= sampleCnt_ff + 4'h1;
        altPhase_ff <= ~altPhase_ff; // R8
      end
    end
  end

  // Result store: only whole conversions reach the buffer
  always @(posedge sys_clk) begin
    if (convDone && moduleOn) begin
      resultBuf[wrIdx] <= (chanSel_ff >= `SAS_FIRST_ABSENT) ? 12'h000 : convResultIn; // R3 R11 R15
    end
  end

  // Sample bit: software writes, hardware clears on trigger, sets on auto restart
  wire swCtrl1Wr = busWr & (wb_adr_i == `SAS_OFS_CTRL1) & wb_sel_i[0];
  always @(posedge sys_clk) begin
    if (rst) begin
      sampleBit_ff <= 1'b0;
    end else if (convDone && moduleOn && autoSample) begin
      sampleBit_ff <= 1'b1; // R23
    end else if (state_ff[1] && moduleOn && convTrig && trigSrc != `SAS_TRIG_SW) begin
      sampleBit_ff <= 1'b0;
    end else if (swCtrl1Wr) begin
      sampleBit_ff <= wb_dat_i[`SAS_C1_SAMPLE_BIT]; // R2 R12
    end else if (state_ff[0] && moduleOn && autoSample) begin
      sampleBit_ff <= 1'b1; // R23
    end
  end

  // Done and interrupt flags; a set in the same cycle beats a clear
  always @(posedge sys_clk) begin
    if (rst) begin
      doneBit_ff <= 1'b0;
      convIrqFlag_ff <= 1'b0;
    end else begin
      if (lastOfGroup) begin
        doneBit_ff <= 1'b1; // R3
      end else if (swCtrl1Wr && !wb_dat_i[`SAS_C1_DONE]) begin
        doneBit_ff <= 1'b0;
      end else if (state_ff[0] && nxt_state[1]) begin
        doneBit_ff <= 1'b0;
      end
      if (lastOfGroup) begin
        convIrqFlag_ff <= 1'b1; // R3
      end else if (busWr && wb_adr_i == `SAS_OFS_FLAG && wb_sel_i[0] && wb_dat_i[`SAS_FL_IF]) begin
        convIrqFlag_ff <= 1'b0;
      end
    end
  end

  // Wishbone slave: configuration registers
  always @(posedge sys_clk) begin
    if (rst) begin
      ctrl1_ff <= `SAS_RST_REG16;
      ctrl2_ff <= `SAS_RST_REG16;
      ctrl3_ff <= `SAS_RST_REG16;
      inSel_ff <= `SAS_RST_REG16;
      portCfg_ff <= `SAS_RST_REG16;
      scanSel_ff <= `SAS_RST_REG16;
    end else if (busWr) begin
      case (wb_adr_i)
        `SAS_OFS_CTRL1: ctrl1_ff <= lane_merge(ctrl1_ff, wb_dat_i[15:0], wb_sel_i[1:0]);
        `SAS_OFS_CTRL2: ctrl2_ff <= lane_merge(ctrl2_ff, wb_dat_i[15:0], wb_sel_i[1:0]);
        `SAS_OFS_CTRL3: ctrl3_ff <= lane_merge(ctrl3_ff, wb_dat_i[15:0], wb_sel_i[1:0]);
        `SAS_OFS_INSEL: inSel_ff <= lane_merge(inSel_ff, wb_dat_i[15:0], wb_sel_i[1:0]);
        `SAS_OFS_PCFG: portCfg_ff <= lane_merge(portCfg_ff, wb_dat_i[15:0], wb_sel_i[1:0]);
        `SAS_OFS_SCAN: scanSel_ff <= lane_merge(scanSel_ff, wb_dat_i[15:0], wb_sel_i[1:0]);
        default: ctrl1_ff <= ctrl1_ff;
      endcase
    end
  end

  // Read mux; buffer words ignore writes
  reg [15:0] rdWord;
  always @* begin
    rdWord = 16'h0000;
    if (wb_adr_i[7:6] == 2'h1 && wb_adr_i[1:0] == 2'h0) begin
      rdWord = format_word(resultBuf[wb_adr_i[5:2]], formatSel); // R1 R24
    end else begin
      case (wb_adr_i)
        `SAS_OFS_CTRL1: rdWord = {ctrl1_ff[15:3], ctrl1_ff[`SAS_C1_AUTO_SAMPLE_BIT], sampleBit_ff, doneBit_ff};
        `SAS_OFS_CTRL2: rdWord = {ctrl2_ff[15:8], bufHalf_ff, ctrl2_ff[6:0]};
        `SAS_OFS_CTRL3: rdWord = ctrl3_ff;
        `SAS_OFS_INSEL: rdWord = inSel_ff;
        `SAS_OFS_PCFG: rdWord = portCfg_ff;
        `SAS_OFS_SCAN: rdWord = scanSel_ff;
        `SAS_OFS_FLAG: rdWord = {15'h0000, convIrqFlag_ff};
        default: rdWord = 16'h0000;
      endcase
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= busReq;
      wb_dat_o <= busReq ? {16'h0000, rdWord} : 32'h0000_0000;
    end
  end

endmodule // sas_sar_adc_sequencer
